/* src/pof_pkg.sv */
// Constants and types shared by the position offset filter.
// Assumes a 50 MHz system clock and binary-coded position values.
package pof_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int LATCH_HOLD_MS = 5;
	localparam int LATCH_HOLD_CYC = (LATCH_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POS_W = 8;
	localparam logic [7:0] OFFSET_MIN = 8'h01;
	localparam logic [7:0] OFFSET_SPAN_TOP = 8'h60;
	localparam logic [7:0] OFFSET_RESET = 8'h01;
	localparam logic [7:0] LOCAL_POS_RESET = 8'h01;
	localparam logic [7:0] CMD_CH0 = 8'h53;
	localparam logic [7:0] CMD_CH1 = 8'h4f;
	localparam logic [7:0] CMD_END = 8'h0d;
	localparam logic [7:0] DIGIT_ZERO = 8'h30;
	localparam logic [7:0] DIGIT_NINE = 8'h39;
	localparam logic [7:0] VALUE_SAT = 8'hff;
	localparam logic [7:0] DECIMAL_TEN = 8'h0a;
	typedef enum logic [1:0] {PARSE_IDLE, PARSE_CH1, PARSE_DIGITS} pof_parse_type;
	typedef enum logic [0:0] {MOVE_IDLE, MOVE_RUN} pof_move_type;
endpackage

/* src/pof_hold_timer.sv */
// Latch strobe qualifier: fires once after the strobe fell and stayed low.
// Assumes a strobe synchronous to the system clock.
`timescale 1ns/1ns
`default_nettype none
module pof_hold_timer #(
	parameter int HOLD_CYC = pof_pkg::LATCH_HOLD_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic strobe_n_i,
	output logic fire_o
);
	typedef struct packed {
		logic prev;
		logic armed;
		logic [31:0] count;
		logic fire;
	} pof_hold_type;

	pof_hold_type s_q;
	pof_hold_type s_d;

	////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.fire = 1'b0;
		s_d.prev = strobe_n_i;
		if (strobe_n_i) begin
			s_d.armed = 1'b0;
			s_d.count = '0;
		end else if (s_q.prev) begin
			s_d.armed = 1'b1;
			s_d.count = 32'h00000001;
		end else if (s_q.armed) begin
			if (s_q.count >= 32'(HOLD_CYC)) begin
				s_d.fire = 1'b1;
				s_d.armed = 1'b0;
			end else begin
				s_d.count = s_q.count + 32'h00000001;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_q <= '{prev: 1'b1, armed: 1'b0, count: '0, fire: 1'b0};
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign fire_o = s_q.fire;
endmodule
`default_nettype wire

/* src/pof_filter.sv */
// Position window filter: offset command parser, request sampling and move control.
// Assumes a drive that reports motion completion with a one-cycle pulse.
//
// Notes on behaviour
// - Offset accepted only from 1 to 96 minus position count; else rejected.
// - Act only on positions from offset to offset plus count minus one.
// - Offset resets to 1, so ten positions answer requests 1 to 10.
// - Serial offset command is the two mnemonic letters, decimal digits, carriage return.
// - Auto-latch samples parallel inputs on any change, no strobe needed.
// - Latch falling and held low 5 ms samples inputs and attempts move; the latch is ignored while auto-latch is on.
// - Request for occupied position flags error; next successful move clears it.
// - Current-position outputs refresh only after motion completes without error.
`timescale 1ns/1ns
`default_nettype none
module pof_filter #(
	parameter int LATCH_HOLD_CYC = pof_pkg::LATCH_HOLD_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] position_count_i,
	input wire logic auto_latch_i,
	input wire logic latch_n_i,
	input wire logic [7:0] pos_in_i,
	input wire logic [7:0] cmd_byte_i,
	input wire logic cmd_valid_i,
	input wire logic motor_done_i,
	output logic [7:0] offset_o,
	output logic offset_rej_o,
	output logic move_start_o,
	output logic [7:0] move_target_o,
	output logic motor_run_n_o,
	output logic error_n_o,
	output logic [7:0] cur_pos_o
);
	typedef struct packed {
		pof_pkg::pof_parse_type parse;
		logic [7:0] value;
		logic has_digit;
		logic [7:0] offset;
		logic offset_rej;
		logic [7:0] last_in;
		logic auto_prev;
		pof_pkg::pof_move_type move;
		logic move_start;
		logic [7:0] target;
		logic [7:0] local_pos;
		logic err_n;
		logic run_n;
		logic [7:0] cur_pos;
	} pof_state_type;

	pof_state_type s_q;
	pof_state_type s_d;
	logic latch_fire;
	logic take_req;

	////////////////////////////////////////////////////////////////
	pof_hold_timer #(
		.HOLD_CYC(LATCH_HOLD_CYC)
	) u_hold (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.strobe_n_i(latch_n_i),
		.fire_o(latch_fire)
	);

	function automatic logic in_window(input logic [7:0] pos, input logic [7:0] off,
			input logic [7:0] cnt);
		logic [8:0] top;
		top = {1'b0, off} + {1'b0, cnt} - 9'h001;
		in_window = (cnt != 8'h00) && (pos >= off) && ({1'b0, pos} <= top);
	endfunction

	function automatic logic [7:0] dec_step(input logic [7:0] acc, input logic [7:0] ch);
		logic [11:0] sum;
		sum = {4'h0, acc} * {4'h0, pof_pkg::DECIMAL_TEN} + {4'h0, ch - pof_pkg::DIGIT_ZERO};
		dec_step = (sum > {4'h0, pof_pkg::VALUE_SAT}) ? pof_pkg::VALUE_SAT : sum[7:0];
	endfunction

	////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.offset_rej = 1'b0;
		s_d.move_start = 1'b0;
		take_req = 1'b0;
		s_d.last_in = pos_in_i;
		s_d.auto_prev = auto_latch_i;
		if (cmd_valid_i) begin
			case (s_q.parse)
				pof_pkg::PARSE_IDLE: begin
					if (cmd_byte_i == pof_pkg::CMD_CH0) begin
						s_d.parse = pof_pkg::PARSE_CH1;
					end
				end
				pof_pkg::PARSE_CH1: begin
					s_d.value = 8'h00;
					s_d.has_digit = 1'b0;
					s_d.parse = (cmd_byte_i == pof_pkg::CMD_CH1) ? pof_pkg::PARSE_DIGITS
						: pof_pkg::PARSE_IDLE;
				end
				pof_pkg::PARSE_DIGITS: begin
					if (cmd_byte_i >= pof_pkg::DIGIT_ZERO && cmd_byte_i <= pof_pkg::DIGIT_NINE) begin
						s_d.value = dec_step(s_q.value, cmd_byte_i);
						s_d.has_digit = 1'b1;
					end else begin
						s_d.parse = pof_pkg::PARSE_IDLE;
						if (cmd_byte_i == pof_pkg::CMD_END && s_q.has_digit
								&& s_q.value >= pof_pkg::OFFSET_MIN
								&& {1'b0, s_q.value} + {1'b0, position_count_i}
								<= {1'b0, pof_pkg::OFFSET_SPAN_TOP}) begin
							s_d.offset = s_q.value;
						end else begin
							s_d.offset_rej = 1'b1;
						end
					end
				end
				default: begin
					s_d.parse = pof_pkg::PARSE_IDLE;
				end
			endcase
		end
		if (auto_latch_i) begin
			take_req = (pos_in_i != s_q.last_in) || !s_q.auto_prev;
		end else begin
			take_req = latch_fire;
		end
		case (s_q.move)
			pof_pkg::MOVE_IDLE: begin
				if (take_req && in_window(pos_in_i, s_q.offset, position_count_i)) begin
					if (8'(pos_in_i - s_q.offset + 8'h01) == s_q.local_pos) begin
						s_d.err_n = 1'b0;
					end else begin
						s_d.target = 8'(pos_in_i - s_q.offset + 8'h01);
						s_d.move_start = 1'b1;
						s_d.move = pof_pkg::MOVE_RUN;
						s_d.run_n = 1'b0;
					end
				end
			end
			pof_pkg::MOVE_RUN: begin
				// Requests during motion are dropped; the drive owns the shaft
				if (motor_done_i) begin
					s_d.move = pof_pkg::MOVE_IDLE;
					s_d.local_pos = s_q.target;
					s_d.run_n = 1'b1;
					s_d.err_n = 1'b1;
					s_d.cur_pos = 8'(s_q.target + s_q.offset - 8'h01);
				end
			end
			default: begin
				s_d.move = pof_pkg::MOVE_IDLE;
				s_d.run_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.parse <= pof_pkg::PARSE_IDLE;
			s_q.move <= pof_pkg::MOVE_IDLE;
			s_q.offset <= pof_pkg::OFFSET_RESET;
			s_q.local_pos <= pof_pkg::LOCAL_POS_RESET;
			s_q.cur_pos <= pof_pkg::OFFSET_RESET;
			// Both indications idle high out of reset
			s_q.err_n <= 1'b1;
			s_q.run_n <= 1'b1;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign offset_o = s_q.offset;
	assign offset_rej_o = s_q.offset_rej;
	assign move_start_o = s_q.move_start;
	assign move_target_o = s_q.target;
	assign motor_run_n_o = s_q.run_n;
	assign error_n_o = s_q.err_n;
	assign cur_pos_o = s_q.cur_pos;
endmodule
`default_nettype wire

/* src/dummy_unused_none.sv */
// Spare source slot: holds no logic.
// Assumes nothing of its surroundings.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* verif/pof_host_model.sv */
// Host and drive model: strobes the latch, answers moves.
// Assumes one request or move at a time.
`timescale 1ns/1ns
`default_nettype none
module pof_host_model #(parameter int HOLD = 8) (
	input wire logic clk_i, rst_i, go_i, start_i,
	input wire logic [3:0] dly_i,
	output logic latch_n_o, done_o
);
	logic [7:0] lc_q;
	logic [3:0] dc_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lc_q <= 8'h00;
			dc_q <= 4'h0;
		end else begin
			lc_q <= go_i ? 8'(HOLD + 4) : lc_q - 8'(lc_q != 8'h00);
			// Variable delay, never zero
			dc_q <= start_i ? (dly_i | 4'h1) : dc_q - 4'(dc_q != 4'h0);
		end
	end
	assign latch_n_o = lc_q == 8'h00;
	assign done_o = dc_q == 4'h1;
endmodule
`default_nettype wire

/* verif/pof_filter_checker.sv */
// Assertions on the filter ports.
// Assumes ce_i held high.
`timescale 1ns/1ns
`default_nettype none
module pof_filter_checker (
	input wire logic sys_clk_i, rst_i, ce_i, auto_latch_i, latch_n_i, cmd_valid_i,
	input wire logic motor_done_i, offset_rej_o, move_start_o, motor_run_n_o, error_n_o,
	input wire logic [7:0] position_count_i, pos_in_i, cmd_byte_i, offset_o,
	input wire logic [7:0] move_target_o, cur_pos_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	a_rej_pulse: assert property (offset_rej_o |=> !offset_rej_o)
		else $error("reject held");
	a_offset_span: assert property ($changed(offset_o) |-> offset_o >= 8'h01 &&
		9'(offset_o) + 9'(position_count_i) <= 9'h060) else $error("offset span");
	a_target_window: assert property (move_start_o |-> move_target_o >= 8'h01 &&
		move_target_o <= position_count_i) else $error("target window");
	a_start_runs: assert property (move_start_o |-> !motor_run_n_o ##1 !move_start_o)
		else $error("start pulse");
	a_run_cause: assert property ($fell(motor_run_n_o) |-> move_start_o)
		else $error("run cause");
	a_run_stop: assert property (motor_done_i && !motor_run_n_o |=> motor_run_n_o)
		else $error("run stop");
	a_err_set: assert property ($fell(error_n_o) |-> motor_run_n_o)
		else $error("error set");
	a_err_clear: assert property ($rose(error_n_o) |-> $past(motor_done_i))
		else $error("error clear");
endmodule
bind pof_filter pof_filter_checker chk (.*);
`default_nettype wire

/* verif/pof_filter_test.sv */
// Self-checking bench for the filter.
// Assumes the host model strobes the latch and ends moves.
`timescale 1ns/1ns
`default_nettype none
module pof_filter_test;
	logic sys_clk_i = 0, rst_i = 1, auto_latch_i = 1, cmd_valid_i = 0, go = 0;
	logic latch_n, done, rej = 0, err_e = 1, moved = 1, ok;
	logic offset_rej_o, move_start_o, motor_run_n_o, error_n_o;
	logic [7:0] cnt = 8'h0a, pos_in_i = 0, cmd_byte_i = 0, off = 8'h01, loc = 8'h01;
	logic [7:0] offset_o, move_target_o, cur_pos_o;
	logic [3:0] dly = 4'h3;
	int err_count = 0, checks = 0, seed = 53383, r;
	always #10 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) if (offset_rej_o === 1'b1) rej = 1;
	pof_filter #(.LATCH_HOLD_CYC(8)) uut (.sys_clk_i, .rst_i, .ce_i(1'b1),
		.position_count_i(cnt), .auto_latch_i, .latch_n_i(latch_n), .pos_in_i,
		.cmd_byte_i, .cmd_valid_i, .motor_done_i(done), .offset_o, .offset_rej_o,
		.move_start_o, .move_target_o, .motor_run_n_o, .error_n_o, .cur_pos_o);
	pof_host_model #(.HOLD(8)) host (.clk_i(sys_clk_i), .rst_i, .go_i(go),
		.start_i(move_start_o), .dly_i(dly), .latch_n_o(latch_n), .done_o(done));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic set_off(input logic [7:0] v);
		logic [7:0] b[5];
		b = '{8'h53, 8'h4f, 8'h30 + v / 8'd10, 8'h30 + v % 8'd10, 8'h0d};
		rej = 0;
		foreach (b[i]) begin
			@(posedge sys_clk_i);
			cmd_byte_i <= b[i];
			cmd_valid_i <= 1'b1;
		end
		@(posedge sys_clk_i);
		cmd_valid_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		ok = v >= 8'h01 && 9'(v) + 9'(cnt) <= 9'h060;
		if (ok) off = v;
		moved = moved && !ok;
		chk("offset", offset_o, off);
		chk("reject", {7'h0, rej}, {7'h0, !ok});
	endtask
	// Strobe only matters with auto-latch off
	task automatic req(input logic [7:0] p, input logic s);
		@(posedge sys_clk_i);
		pos_in_i <= 8'h00;
		@(posedge sys_clk_i);
		pos_in_i <= p;
		go <= s;
		@(posedge sys_clk_i);
		go <= 1'b0;
		repeat (40) @(posedge sys_clk_i);
		if ((auto_latch_i || s) && p >= off && p - off < cnt) begin
			err_e = p - off + 8'h01 != loc;
			moved = moved || err_e;
			if (err_e) loc = p - off + 8'h01;
		end
		chk("error_n", {7'h0, error_n_o}, {7'h0, err_e});
		if (moved) chk("cur_pos", cur_pos_o, loc + off - 8'h01);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		chk("offset_reset", offset_o, 8'h01);
		chk("cur_reset", cur_pos_o, 8'h01);
		req(8'h0a, 1'b0);
		req(8'h0a, 1'b0);
		req(8'h0b, 1'b0);
		repeat (12) begin
			r = $random(seed);
			dly <= r[11:8];
			req(r[7:0] % 8'd24, 1'b0);
		end
		cnt <= 8'h10;
		set_off(8'h51);
		set_off(8'h00);
		set_off(8'h50);
		set_off(8'h10);
		req(8'h10, 1'b0);
		req(8'h1f, 1'b0);
		req(8'h20, 1'b0);
		req(8'h0f, 1'b0);
		auto_latch_i <= 1'b0;
		req(8'h12, 1'b0);
		repeat (8) begin
			r = $random(seed);
			req(8'h10 + r[7:0] % 8'd20, r[8]);
		end
		complete_run();
	end
	initial begin
		repeat (8000) @(posedge sys_clk_i);
		err_count++;
		complete_run();
	end
endmodule
`default_nettype wire
